/* File: gpio_pad_cfg.svh */
// register map, field positions and reset values of the pad block
`ifndef GPIO_PAD_CFG_SVH
`define GPIO_PAD_CFG_SVH
// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define PINS_DEFAULT 45
`define LP_PIN_FIRST 24
`define LP_PIN_LAST 27
// ----------------------------------------------------------------
// word addresses, even word low pins, odd word high pins
// ----------------------------------------------------------------
`define ADDR_IN_LEVEL 8'h00
`define ADDR_OUT_ENABLE 8'h02
`define ADDR_OUT_VALUE 8'h08
`define ADDR_TRIG_KIND 8'h0e
`define ADDR_TRIG_HIGH 8'h14
`define ADDR_TRIG_LOW 8'h1a
`define ADDR_IRQ_STATUS 8'h20
`define ADDR_LP_ENABLE 8'h22
`define ADDR_SERIAL_ROUTE 8'h40
`define ADDR_TIMER_ROUTE 8'h60
`define ADDR_PAD_CFG 8'h80
`define OFS_SETTER 8'h02
`define OFS_CLEARER 8'h04
// ----------------------------------------------------------------
// pad config word fields
// ----------------------------------------------------------------
`define CFG_FUNCTION_SELECT_LSB 0
`define CFG_FUNCTION_SELECT_MSB 2
`define CFG_DS_LSB 3
`define CFG_DS_MSB 4
`define CFG_PULL_EN 5
`define CFG_PULL_DIR 6
`define CFG_INPUT_GATE 7
`define CFG_RESET 8'h20
`define ROUTE_RESET 6'h3f
`endif

/* File: gpio_pad_pkg.sv */
// types and word helpers of the pad block
package gpio_pad_pkg;
  typedef enum logic [2:0] {
    FUNCTION_SELECT_GPIO = 3'h0,
    FUNCTION_SELECT_ALT1 = 3'h1,
    FUNCTION_SELECT_ALT2 = 3'h2,
    FUNCTION_SELECT_ALT3 = 3'h3,
    FUNCTION_SELECT_SERIAL = 3'h4,
    FUNCTION_SELECT_TIMER = 3'h5,
    FUNCTION_SELECT_ALT6 = 3'h6,
    FUNCTION_SELECT_ALT7 = 3'h7
  } function_select_t;
  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_WRITE = 2'h1,
    OP_SET = 2'h2,
    OP_CLEAR = 2'h3
  } bank_op_t;
  typedef logic [5:0] pin_route_t;

  function automatic logic [63:0] spread(input logic [31:0] d, input logic hi);
    spread = hi ? {d, 32'h0} : {32'h0, d};
  endfunction : spread

  function automatic logic [31:0] word_of(input logic [63:0] v, input logic hi);
    word_of = hi ? v[63:32] : v[31:0];
  endfunction : word_of
endpackage : gpio_pad_pkg

/* File: bank_if.sv */
// write port and value of one per-pin bit bank
`timescale 1ns/1ps
interface bank_if #(parameter int W = 45);
  gpio_pad_pkg::bank_op_t op;
  logic hi;
  logic [31:0] wdata;
  logic [W-1:0] value;
  modport ctrl (output op, output hi, output wdata, input value);
  modport bank (input op, input hi, input wdata, output value);
endinterface : bank_if

/* File: bit_bank.sv */
// one bit per pin with direct, set and clear writes
`timescale 1ns/1ps
module bit_bank #(
  parameter int W = 45,
  parameter logic [W-1:0] MASK = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bank port
  bank_if.bank port
);
  typedef struct packed {
    logic [W-1:0] value;
  } state_t;
  state_t st_reg;
  state_t st_next;
  logic [63:0] d;
  logic [63:0] lane;

  initial begin
    if (W < 33 || W > 64) $error("bit_bank width out of range");
  end

  always_comb begin
    st_next = st_reg;
    d = gpio_pad_pkg::spread(port.wdata, port.hi);
    lane = gpio_pad_pkg::spread(32'hffffffff, port.hi);
    unique case (port.op)
      gpio_pad_pkg::OP_WRITE: st_next.value = (st_reg.value & ~lane[W-1:0]) | d[W-1:0];
      gpio_pad_pkg::OP_SET: st_next.value = st_reg.value | d[W-1:0];
      gpio_pad_pkg::OP_CLEAR: st_next.value = st_reg.value & ~d[W-1:0];
      gpio_pad_pkg::OP_NONE: st_next.value = st_reg.value;
    endcase
    st_next.value = st_next.value & MASK;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign port.value = st_reg.value;
endmodule : bit_bank

/* File: gpio_pad_mux.sv */
// pad mux, pull and drive controls, gpio output and pin events
`timescale 1ns/1ps
`include "gpio_pad_cfg.svh"
// Notes on behaviour
// - 33 to 63 pins, independent config
// - two-bit drive code 0..3, stronger upward
// - output and enable follow function select
// - input gate passes level to function
// - pull enable and direction pick resistor
// - gpio level and events always available
// - code 4 routes serial signals by pin
// - code 5 routes timer channels by pin
// - pull enable resets to one
// - gpio bits map pins across two words
// - enable bit one drives the pin
// - value bit sets driven level
// - set and clear touch addressed bits only
// - pins 24..27 with lp enable bit set keep driving in low power
// - level or edge trigger selection
// - status shows events, write one clears
module gpio_pad_mux #(
  parameter int NUM_PINS = `PINS_DEFAULT,
  parameter int N_SERIAL = 8,
  parameter int N_TIMER = 8,
  parameter logic [NUM_PINS-1:0] PULL_UP_RESET = '0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // pads
  input wire logic [NUM_PINS-1:0] pad_in,
  output logic [NUM_PINS-1:0] pad_out,
  output logic [NUM_PINS-1:0] pad_oe,
  output logic [NUM_PINS-1:0] pad_pull_up,
  output logic [NUM_PINS-1:0] pad_pull_down,
  output logic [NUM_PINS-1:0][1:0] pad_drive,
  // low power
  input wire logic lp_mode,
  // dedicated peripheral functions, indexed by function code
  input wire logic [7:0][NUM_PINS-1:0] alt_out,
  input wire logic [7:0][NUM_PINS-1:0] alt_oe,
  output logic [7:0][NUM_PINS-1:0] alt_in,
  // shared serial signals
  input wire logic [N_SERIAL-1:0] serial_out,
  input wire logic [N_SERIAL-1:0] serial_oe,
  output logic [N_SERIAL-1:0] serial_in,
  // shared timer channels
  input wire logic [N_TIMER-1:0] timer_out,
  input wire logic [N_TIMER-1:0] timer_oe,
  output logic [N_TIMER-1:0] timer_in,
  // pin events
  output logic [NUM_PINS-1:0] pin_level,
  output logic irq_pending
);
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  initial begin
    if (NUM_PINS < 33 || NUM_PINS > 63) $error("NUM_PINS out of range");
    if (N_SERIAL < 1 || N_SERIAL > 32) $error("N_SERIAL out of range");
    if (N_TIMER < 1 || N_TIMER > 32) $error("N_TIMER out of range");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_PINS-1:0][7:0] pad_cfg;
    logic [N_SERIAL-1:0][5:0] serial_route;
    logic [N_TIMER-1:0][5:0] timer_route;
    logic [NUM_PINS-1:0] irq_status;
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe;
    logic [NUM_PINS-1:0] pull_up;
    logic [NUM_PINS-1:0] pull_down;
    logic [NUM_PINS-1:0][1:0] drive;
    logic [7:0][NUM_PINS-1:0] alt_in;
    logic [N_SERIAL-1:0] serial_in;
    logic [N_TIMER-1:0] timer_in;
    logic [NUM_PINS-1:0] level;
    logic irq_pending;
    logic [31:0] rdata;
  } state_t;
  state_t st_reg;
  state_t st_next;
  localparam logic [NUM_PINS-1:0] LP_MASK =
    NUM_PINS'(((64'h1 << (`LP_PIN_LAST + 1)) - 1) & ~((64'h1 << `LP_PIN_FIRST) - 1));
  // ----------------------------------------------------------------
  // bit banks
  // ----------------------------------------------------------------
  bank_if #(.W(NUM_PINS)) oe_bus ();
  bank_if #(.W(NUM_PINS)) val_bus ();
  bank_if #(.W(NUM_PINS)) kind_bus ();
  bank_if #(.W(NUM_PINS)) high_bus ();
  bank_if #(.W(NUM_PINS)) low_bus ();
  bank_if #(.W(NUM_PINS)) lp_bus ();
  function automatic gpio_pad_pkg::bank_op_t decode_op(input logic [7:0] a,
      input logic [7:0] base, input logic w, input logic sc);
    logic [7:0] s;
    logic [7:0] c;
    s = base + `OFS_SETTER;
    c = base + `OFS_CLEARER;
    decode_op = gpio_pad_pkg::OP_NONE;
    if (w && a[7:1] == base[7:1]) decode_op = gpio_pad_pkg::OP_WRITE;
    if (w && sc && a[7:1] == s[7:1]) decode_op = gpio_pad_pkg::OP_SET;
    if (w && sc && a[7:1] == c[7:1]) decode_op = gpio_pad_pkg::OP_CLEAR;
  endfunction : decode_op
  assign oe_bus.op = decode_op(reg_addr, `ADDR_OUT_ENABLE, reg_wr, 1'b1);
  assign val_bus.op = decode_op(reg_addr, `ADDR_OUT_VALUE, reg_wr, 1'b1);
  assign kind_bus.op = decode_op(reg_addr, `ADDR_TRIG_KIND, reg_wr, 1'b1);
  assign high_bus.op = decode_op(reg_addr, `ADDR_TRIG_HIGH, reg_wr, 1'b1);
  assign low_bus.op = decode_op(reg_addr, `ADDR_TRIG_LOW, reg_wr, 1'b1);
  assign lp_bus.op = decode_op(reg_addr, `ADDR_LP_ENABLE, reg_wr, 1'b0);
  assign oe_bus.hi = reg_addr[0];
  assign val_bus.hi = reg_addr[0];
  assign kind_bus.hi = reg_addr[0];
  assign high_bus.hi = reg_addr[0];
  assign low_bus.hi = reg_addr[0];
  assign lp_bus.hi = reg_addr[0];
  assign oe_bus.wdata = reg_wdata;
  assign val_bus.wdata = reg_wdata;
  assign kind_bus.wdata = reg_wdata;
  assign high_bus.wdata = reg_wdata;
  assign low_bus.wdata = reg_wdata;
  assign lp_bus.wdata = reg_wdata;
  bit_bank #(.W(NUM_PINS)) u_oe (.clk(sys_clk), .rst_n(rst_n), .port(oe_bus));
  bit_bank #(.W(NUM_PINS)) u_val (.clk(sys_clk), .rst_n(rst_n), .port(val_bus));
  bit_bank #(.W(NUM_PINS)) u_kind (.clk(sys_clk), .rst_n(rst_n), .port(kind_bus));
  bit_bank #(.W(NUM_PINS)) u_high (.clk(sys_clk), .rst_n(rst_n), .port(high_bus));
  bit_bank #(.W(NUM_PINS)) u_low (.clk(sys_clk), .rst_n(rst_n), .port(low_bus));
  bit_bank #(.W(NUM_PINS), .MASK(LP_MASK)) u_lp (.clk(sys_clk), .rst_n(rst_n), .port(lp_bus));
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [63:0] wide;
  logic [NUM_PINS-1:0] rise;
  logic [NUM_PINS-1:0] fall;
  logic [NUM_PINS-1:0] cond;
  logic [NUM_PINS-1:0] clr;
  logic [7:0] idx;
  gpio_pad_pkg::function_select_t fs;
  logic o;
  logic e;
  logic [5:0] r;
  always_comb begin
    st_next = st_reg;
    wide = 64'h0;
    clr = '0;
    o = 1'b0;
    e = 1'b0;
    r = 6'h0;
    idx = 8'h0;
    fs = gpio_pad_pkg::FUNCTION_SELECT_GPIO;
    // register writes
    if (reg_wr) begin
      idx = reg_addr - `ADDR_PAD_CFG;
      if (reg_addr >= `ADDR_PAD_CFG && idx < 8'(NUM_PINS)) begin
        st_next.pad_cfg[idx[5:0]] = reg_wdata[7:0];
      end
      idx = reg_addr - `ADDR_SERIAL_ROUTE;
      if (reg_addr >= `ADDR_SERIAL_ROUTE && idx < 8'(N_SERIAL)) begin
        st_next.serial_route[idx[4:0]] = reg_wdata[5:0];
      end
      idx = reg_addr - `ADDR_TIMER_ROUTE;
      if (reg_addr >= `ADDR_TIMER_ROUTE && idx < 8'(N_TIMER)) begin
        st_next.timer_route[idx[4:0]] = reg_wdata[5:0];
      end
      if (reg_addr[7:1] == 7'(`ADDR_IRQ_STATUS >> 1)) begin
        wide = gpio_pad_pkg::spread(reg_wdata, reg_addr[0]);
        clr = wide[NUM_PINS-1:0];
      end
    end
    // pin events
    st_next.level = pad_in;
    rise = pad_in & ~st_reg.level;
    fall = ~pad_in & st_reg.level;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (kind_bus.value[i]) begin
        cond[i] = (high_bus.value[i] & rise[i]) | (low_bus.value[i] & fall[i]);
      end else begin
        cond[i] = (high_bus.value[i] & ~low_bus.value[i] & pad_in[i])
          | (low_bus.value[i] & ~high_bus.value[i] & ~pad_in[i]);
      end
    end
    st_next.irq_status = (st_reg.irq_status & ~clr) | cond;
    st_next.irq_pending = |st_next.irq_status;
    // pad controls and output mux
    st_next.serial_in = '0;
    st_next.timer_in = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      fs = gpio_pad_pkg::function_select_t'(st_reg.pad_cfg[i][`CFG_FUNCTION_SELECT_MSB:`CFG_FUNCTION_SELECT_LSB]);
      st_next.drive[i] = st_reg.pad_cfg[i][`CFG_DS_MSB:`CFG_DS_LSB];
      st_next.pull_up[i] = st_reg.pad_cfg[i][`CFG_PULL_EN] & st_reg.pad_cfg[i][`CFG_PULL_DIR];
      st_next.pull_down[i] = st_reg.pad_cfg[i][`CFG_PULL_EN]
        & ~st_reg.pad_cfg[i][`CFG_PULL_DIR];
      for (int k = 0; k < 8; k++) begin
        st_next.alt_in[k][i] = pad_in[i] & st_reg.pad_cfg[i][`CFG_INPUT_GATE]
          & (fs == gpio_pad_pkg::function_select_t'(k));
      end
      o = 1'b0;
      e = 1'b0;
      unique case (fs)
        gpio_pad_pkg::FUNCTION_SELECT_GPIO: begin
          o = val_bus.value[i];
          e = oe_bus.value[i];
        end
        gpio_pad_pkg::FUNCTION_SELECT_SERIAL: begin
          for (int j = 0; j < N_SERIAL; j++) begin
            if (st_reg.serial_route[j] == 6'(i)) begin
              o = o | serial_out[j];
              e = e | serial_oe[j];
            end
          end
        end
        gpio_pad_pkg::FUNCTION_SELECT_TIMER: begin
          for (int j = 0; j < N_TIMER; j++) begin
            if (st_reg.timer_route[j] == 6'(i)) begin
              o = o | timer_out[j];
              e = e | timer_oe[j];
            end
          end
        end
        default: begin
          o = alt_out[fs][i];
          e = alt_oe[fs][i];
        end
      endcase
      if (!lp_mode) begin
        st_next.out[i] = o;
        st_next.oe[i] = e;
      end else if (!lp_bus.value[i]) begin
        st_next.oe[i] = 1'b0;
      end
    end
    // routed inputs
    for (int j = 0; j < N_SERIAL; j++) begin
      r = st_reg.serial_route[j];
      if (r < 6'(NUM_PINS) && st_reg.pad_cfg[r][`CFG_FUNCTION_SELECT_MSB:`CFG_FUNCTION_SELECT_LSB] == 3'h4) begin
        st_next.serial_in[j] = pad_in[r] & st_reg.pad_cfg[r][`CFG_INPUT_GATE];
      end
    end
    for (int j = 0; j < N_TIMER; j++) begin
      r = st_reg.timer_route[j];
      if (r < 6'(NUM_PINS) && st_reg.pad_cfg[r][`CFG_FUNCTION_SELECT_MSB:`CFG_FUNCTION_SELECT_LSB] == 3'h5) begin
        st_next.timer_in[j] = pad_in[r] & st_reg.pad_cfg[r][`CFG_INPUT_GATE];
      end
    end
    // read data
    st_next.rdata = 32'h0;
    if (reg_rd) begin
      unique case (reg_addr[7:1])
        7'(`ADDR_IN_LEVEL >> 1): wide = 64'(pad_in);
        7'(`ADDR_OUT_ENABLE >> 1): wide = 64'(oe_bus.value);
        7'(`ADDR_OUT_VALUE >> 1): wide = 64'(val_bus.value);
        7'(`ADDR_TRIG_KIND >> 1): wide = 64'(kind_bus.value);
        7'(`ADDR_TRIG_HIGH >> 1): wide = 64'(high_bus.value);
        7'(`ADDR_TRIG_LOW >> 1): wide = 64'(low_bus.value);
        7'(`ADDR_IRQ_STATUS >> 1): wide = 64'(st_reg.irq_status);
        7'(`ADDR_LP_ENABLE >> 1): wide = 64'(lp_bus.value);
        default: wide = 64'h0;
      endcase
      st_next.rdata = gpio_pad_pkg::word_of(wide, reg_addr[0]);
      idx = reg_addr - `ADDR_PAD_CFG;
      if (reg_addr >= `ADDR_PAD_CFG && idx < 8'(NUM_PINS)) begin
        st_next.rdata = {24'h0, st_reg.pad_cfg[idx[5:0]]};
      end
      idx = reg_addr - `ADDR_SERIAL_ROUTE;
      if (reg_addr >= `ADDR_SERIAL_ROUTE && idx < 8'(N_SERIAL)) begin
        st_next.rdata = {26'h0, st_reg.serial_route[idx[4:0]]};
      end
      idx = reg_addr - `ADDR_TIMER_ROUTE;
      if (reg_addr >= `ADDR_TIMER_ROUTE && idx < 8'(N_TIMER)) begin
        st_next.rdata = {26'h0, st_reg.timer_route[idx[4:0]]};
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      for (int i = 0; i < NUM_PINS; i++) begin
        st_reg.pad_cfg[i] <= `CFG_RESET | (8'(PULL_UP_RESET[i]) << `CFG_PULL_DIR);
      end
      for (int j = 0; j < N_SERIAL; j++) begin
        st_reg.serial_route[j] <= `ROUTE_RESET;
      end
      for (int j = 0; j < N_TIMER; j++) begin
        st_reg.timer_route[j] <= `ROUTE_RESET;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = st_reg.rdata;
  assign pad_out = st_reg.out;
  assign pad_oe = st_reg.oe;
  assign pad_pull_up = st_reg.pull_up;
  assign pad_pull_down = st_reg.pull_down;
  assign pad_drive = st_reg.drive;
  assign alt_in = st_reg.alt_in;
  assign serial_in = st_reg.serial_in;
  assign timer_in = st_reg.timer_in;
  assign pin_level = st_reg.level;
  assign irq_pending = st_reg.irq_pending;
endmodule : gpio_pad_mux

/* File: gpio_pad_mux_asserts.sv */
// port assertions of the pad block
`timescale 1ns/1ps
module gpio_pad_mux_asserts #(
  parameter int NUM_PINS = 45
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // pads
  input wire logic [NUM_PINS-1:0] pad_in,
  input wire logic [NUM_PINS-1:0] pad_out,
  input wire logic [NUM_PINS-1:0] pad_oe,
  input wire logic [NUM_PINS-1:0] pad_pull_up,
  input wire logic [NUM_PINS-1:0] pad_pull_down,
  input wire logic lp_mode,
  input wire logic [NUM_PINS-1:0] pin_level
);
  logic [2:0] up_reg;
  logic cfg_reg;
  logic ok;
  // cycles since reset, any pad config write seen
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      up_reg <= 3'h0;
      cfg_reg <= 1'b0;
    end else begin
      if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
      if (reg_wr && reg_addr[7]) cfg_reg <= 1'b1;
    end
  end
  assign ok = (up_reg == 3'h7) && !cfg_reg && !lp_mode;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  AST_PULL_EXCL: assert property ((pad_pull_up & pad_pull_down) == '0)
    else $error("pull-up and pull-down both on");
  AST_PULL_RESET: assert property (ok |-> pad_pull_down == '1 && pad_pull_up == '0)
    else $error("pull not at reset setting");
  AST_PIN_LEVEL: assert property (up_reg == 3'h7 |-> pin_level == $past(pad_in))
    else $error("pin level not following pad");
  AST_OE_WRITE: assert property (ok && reg_wr && reg_addr == 8'h02 ##1 ok
    |-> ##1 pad_oe[31:0] == $past(reg_wdata, 2))
    else $error("low enable word not on pads");
  AST_OE_HIGH: assert property (ok && reg_wr && reg_addr == 8'h03 ##1 ok
    |-> ##1 pad_oe[NUM_PINS-1:32] == $past(reg_wdata[NUM_PINS-33:0], 2))
    else $error("high enable word not on pads");
  AST_OUT_WRITE: assert property (ok && reg_wr && reg_addr == 8'h08 ##1 ok
    |-> ##1 pad_out[31:0] == $past(reg_wdata, 2))
    else $error("value word not on pads");
  AST_OUT_SET: assert property (ok && reg_wr && reg_addr == 8'h0a ##1 ok
    |-> ##1 pad_out[31:0] == ($past(pad_out[31:0]) | $past(reg_wdata, 2)))
    else $error("value set wrong");
  AST_OUT_CLR: assert property (ok && reg_wr && reg_addr == 8'h0c ##1 ok
    |-> ##1 pad_out[31:0] == ($past(pad_out[31:0]) & ~$past(reg_wdata, 2)))
    else $error("value clear wrong");
endmodule : gpio_pad_mux_asserts

bind gpio_pad_mux gpio_pad_mux_asserts #(.NUM_PINS(NUM_PINS)) u_asserts (
  .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
  .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .lp_mode(lp_mode),
  .pin_level(pin_level)
);

/* File: pin_model.sv */
// board circuitry resolving each pin level
`timescale 1ns/1ps
module pin_model #(
  parameter int N = 45
) (
  // clock
  input wire logic sys_clk,
  // pads from the block
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] pad_pull_up,
  input wire logic [N-1:0] pad_pull_down,
  // board drivers
  input wire logic [N-1:0] ext_val,
  input wire logic [N-1:0] ext_en,
  // resolved levels
  output logic [N-1:0] pad_in
);
  logic [N-1:0] float_reg = '0;
  // floating pin wanders every cycle
  always_ff @(posedge sys_clk) begin
    float_reg <= ~float_reg;
  end
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pull_up[i]) pad_in[i] = 1'b1;
      else if (pad_pull_down[i]) pad_in[i] = 1'b0;
      else pad_in[i] = float_reg[i];
    end
  end
endmodule : pin_model

/* File: gpio_pad_mux_bench.sv */
// self-checking bench of the pad block
`timescale 1ns/1ps
module gpio_pad_mux_bench;
  localparam int N = 45;
  logic sys_clk, reset_n, reg_wr, reg_rd, lp_mode, irq_pending;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [N-1:0] pad_in, pad_out, pad_oe, pull_up, pull_dn, ext_val, ext_en, pin_level;
  logic [N-1:0][1:0] pad_drive;
  logic [7:0][N-1:0] alt_out, alt_oe, alt_in;
  logic [7:0] serial_out, serial_oe, serial_in, timer_out, timer_oe, timer_in;
  int error_cnt = 0;
  int n_checks = 0;
  int codes[5] = '{1, 2, 3, 6, 7};
  gpio_pad_mux u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pull_up),
    .pad_pull_down(pull_dn), .pad_drive(pad_drive), .lp_mode(lp_mode),
    .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in), .serial_out(serial_out),
    .serial_oe(serial_oe), .serial_in(serial_in), .timer_out(timer_out),
    .timer_oe(timer_oe), .timer_in(timer_in), .pin_level(pin_level),
    .irq_pending(irq_pending));
  pin_model #(.N(N)) u_pins (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pull_up), .pad_pull_down(pull_dn), .ext_val(ext_val), .ext_en(ext_en),
    .pad_in(pad_in));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check($sformatf("reg %h", a), reg_rdata & m, e);
  endtask : rdc
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {reset_n, reg_wr, reg_rd, lp_mode, reg_addr, reg_wdata} = '0;
    {ext_val, ext_en, alt_out, alt_oe, serial_out, serial_oe, timer_out, timer_oe} = '0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    settle();
    check("pull_dn", pull_dn, {N{1'b1}});
    check("pull_up", pull_up, '0);
    check("oe", pad_oe, '0);
    rdc(8'h80, 32'hff, 32'h20);
    rdc(8'h30, '1, 32'h0);
    $display("test reset done");
    wr(8'h02, 32'hf0f0_00ff);
    wr(8'h03, 32'h0000_1001);
    wr(8'h08, 32'h5a5a_00a5);
    wr(8'h09, 32'h0000_1fff);
    settle();
    check("oe", pad_oe, {13'h1001, 32'hf0f0_00ff});
    check("out", pad_out, {13'h1fff, 32'h5a5a_00a5});
    check("level", pin_level & pad_oe, pad_out & pad_oe);
    rdc(8'h00, 32'hf0f0_00ff, 32'h5050_00a5);
    wr(8'h04, 32'h0000_0f00);
    wr(8'h06, 32'h0000_000f);
    wr(8'h0a, 32'h0000_ff00);
    wr(8'h0c, 32'h5a00_0000);
    wr(8'h07, 32'h0000_0001);
    settle();
    check("oe", pad_oe, {13'h1000, 32'hf0f0_0ff0});
    check("out", pad_out, {13'h1fff, 32'h005a_ffa5});
    rdc(8'h02, '1, 32'hf0f0_0ff0);
    rdc(8'h04, '1, 32'h0);
    $display("test gpio out done");
    wr(8'h83, 32'h60);
    settle();
    check("od high", pad_in[3], 1'b1);
    wr(8'h04, 32'h8);
    settle();
    check("od low", {pad_oe[3], pad_in[3]}, 2'b10);
    wr(8'h83, 32'h0);
    wr(8'h06, 32'h8);
    settle();
    check("hi z", {pad_oe[3], pull_up[3], pull_dn[3]}, 3'b000);
    for (int c = 0; c < 16; c++) begin
      wr(8'h85, 32'(c << 3));
      settle();
      check("drive", pad_drive[5], c[1:0]);
      check("pulls", {pull_up[5], pull_dn[5]}, {c[2] & c[3], c[2] & !c[3]});
    end
    $display("test pad cfg done");
    for (int j = 0; j < 5; j++) begin
      alt_out <= 360'h1 << (codes[j] * N + 6);
      alt_oe <= 360'h1 << (codes[j] * N + 6);
      wr(8'h86, 32'h80 | codes[j]);
      settle();
      check("mux", {pad_oe[6], pad_out[6], alt_in[codes[j]][6]}, 3'h7);
      check("other", alt_in[codes[(j + 1) % 5]][6], 1'b0);
      wr(8'h86, codes[j]);
      settle();
      check("gate", alt_in[codes[j]][6], 1'b0);
      rdc(8'h00, 32'h40, 32'h40);
    end
    $display("test mux done");
    wr(8'h87, 32'h84);
    wr(8'h42, 32'h7);
    wr(8'ha6, 32'h85);
    wr(8'h63, 32'd38);
    serial_out <= 8'h04;
    serial_oe <= 8'h04;
    timer_out <= 8'h08;
    timer_oe <= 8'h08;
    settle();
    check("serial", {pad_oe[7], pad_out[7], serial_in}, 10'h304);
    check("timer", {pad_oe[38], pad_out[38], timer_in}, 10'h308);
    serial_out <= 8'h00;
    timer_oe <= 8'h00;
    ext_en[38] <= 1'b1;
    ext_val[38] <= 1'b1;
    settle();
    check("serial lo", {pad_out[7], serial_in}, 9'h000);
    check("timer in", {pad_oe[38], timer_in}, 9'h008);
    $display("test routes done");
    wr(8'h22, 32'hffff_ffff);
    rdc(8'h22, '1, 32'h0f00_0000);
    wr(8'h22, 32'h0100_0000);
    wr(8'h04, 32'h0300_0000);
    settle();
    lp_mode <= 1'b1;
    settle();
    check("lp", pad_oe[25:24], 2'b01);
    lp_mode <= 1'b0;
    $display("test low power done");
    ext_en[14] <= 1'b1;
    wr(8'h0e, 32'h4000);
    wr(8'h14, 32'h4000);
    settle();
    rdc(8'h20, '1, 32'h0);
    ext_val[14] <= 1'b1;
    settle();
    check("irq", irq_pending, 1'b1);
    rdc(8'h20, '1, 32'h4000);
    wr(8'h20, 32'h4000);
    settle();
    rdc(8'h20, '1, 32'h0);
    wr(8'h18, 32'h4000);
    wr(8'h12, 32'h4000);
    wr(8'h1c, 32'h4000);
    settle();
    rdc(8'h20, '1, 32'h0);
    ext_val[14] <= 1'b0;
    settle();
    rdc(8'h20, '1, 32'h4000);
    $display("test events done");
    conclude();
  end
endmodule : gpio_pad_mux_bench
